//--- logic/usb_transfer_status_regs.vh
`ifndef USB_TRANSFER_STATUS_REGS_VH
`define USB_TRANSFER_STATUS_REGS_VH

// register byte offsets
`define USTS_ADDR_STATUS     8'h00
`define USTS_ADDR_FLAGS      8'h04
`define USTS_ADDR_MASK       8'h08

// status register field positions
`define USTS_EP_HI           7
`define USTS_EP_LO           4
`define USTS_DIR_BIT         3
`define USTS_BANK_BIT        2

// flag register bit positions and field width
`define USTS_FLAG_DONE       0
`define USTS_FLAG_OVF        1
`define USTS_FLAG_W          2

// reset values
`define USTS_MASK_RST        2'h0
`define USTS_FLAGS_RST       2'h0

// fifo entry width: endpoint, direction, bank
`define USTS_ENTRY_W         6
`define USTS_FIFO_DEPTH      4

`endif

//--- logic/status_entry_mem.v
`timescale 1ns/1ns
`include "usb_transfer_status_regs.vh"

module status_entry_mem #(
  parameter WIDTH = `USTS_ENTRY_W,
  parameter AW    = 2
) (
  // clock
  input  wire             clk_i,
  // write port
  input  wire             we_i,
  input  wire [AW-1:0]    waddr_i,
  input  wire [WIDTH-1:0] wdata_i,
  // read port
  input  wire [AW-1:0]    raddr_i,
  output reg  [WIDTH-1:0] rdata_o
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // write-first bypass keeps the head view current when pushing into empty
  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    if (we_i && (waddr_i == raddr_i))
    begin
      rdata_o <= wdata_i;
    end
    else
    begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule // status_entry_mem

//--- logic/usb_transfer_status_fifo.v
// Contract
// RULE_01: endpoint number in status bits 7..4
// RULE_02: endpoint field updated per completed transfer
// RULE_03: bit 3 one transmit, zero receive
// RULE_04: bit 2 one odd bank, zero even
// RULE_05: bits 31..8 and 1..0 read zero
// RULE_06: status reads head of four-entry fifo
// RULE_07: software trusts status only while done set
// RULE_08: clearing done flag pops fifo head
// RULE_09: push per transfer, done while unread
`timescale 1ns/1ns
`include "usb_transfer_status_regs.vh"

module usb_transfer_status_fifo #(
  parameter DEPTH_LOG2 = 2
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // transfer engine side, same clock
  input  wire        xfer_done_i,
  input  wire [3:0]  xfer_endpoint_i,
  input  wire        xfer_tx_i,
  input  wire        xfer_odd_i,
  // interrupt and status
  output reg         irq_o,
  output reg         transfer_done_flag_o,
  output reg         fifo_full_o
);

  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam CW    = DEPTH_LOG2 + 1;

  //////////////////////////////////////////////////////////////////////////////
  // fifo pointers and count

  reg  [DEPTH_LOG2-1:0] wr_ptr;
  reg  [DEPTH_LOG2-1:0] rd_ptr;
  reg  [CW-1:0]         count;
  reg  [CW-1:0]         next_count;
  reg                   overflow_flag;
  reg  [1:0]            int_mask;
  wire [`USTS_ENTRY_W-1:0] head_entry;
  wire [`USTS_ENTRY_W-1:0] new_entry;

  function [DEPTH_LOG2-1:0] ptr_inc;
    input [DEPTH_LOG2-1:0] p;
    begin
      ptr_inc = p + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
    end
  endfunction

  wire bus_req   = cyc_i & stb_i & ~ack_o;
  wire bus_write = bus_req & we_i & sel_i[0];
  wire fifo_full  = (count == DEPTH[CW-1:0]);
  wire fifo_empty = (count == {CW{1'b0}});

  // a write of one to the done bit pops the head
  wire pop  = bus_write & (adr_i == `USTS_ADDR_FLAGS)
              & dat_i[`USTS_FLAG_DONE] & ~fifo_empty;  // see RULE_08
  // a full fifo drops the new record and raises overflow, unless a pop frees the head in the same cycle
  wire push = xfer_done_i & (~fifo_full | pop);  // see RULE_09
  wire lost = xfer_done_i & fifo_full & ~pop;

  assign new_entry = {xfer_endpoint_i, xfer_tx_i, xfer_odd_i};  // see RULE_02

  status_entry_mem #(
    .WIDTH (`USTS_ENTRY_W),
    .AW    (DEPTH_LOG2)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (push),
    .waddr_i (wr_ptr),
    .wdata_i (new_entry),
    .raddr_i (pop ? ptr_inc(rd_ptr) : rd_ptr),
    .rdata_o (head_entry)
  );  // see RULE_06

  always @*
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + {{(CW-1){1'b0}}, 1'b1};
    end
    else if (pop && !push)
    begin
      next_count = count - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= {DEPTH_LOG2{1'b0}};
      rd_ptr <= {DEPTH_LOG2{1'b0}};
      count  <= {CW{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop)
      begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      count <= next_count;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // overflow flag and mask

  // set wins over a same-cycle clear
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      overflow_flag <= 1'b0;
      int_mask      <= `USTS_MASK_RST;
    end
    else
    begin
      if (lost)
      begin
        overflow_flag <= 1'b1;
      end
      else if (bus_write && adr_i == `USTS_ADDR_FLAGS && dat_i[`USTS_FLAG_OVF])
      begin
        overflow_flag <= 1'b0;
      end
      if (bus_write && adr_i == `USTS_ADDR_MASK)
      begin
        int_mask <= dat_i[`USTS_FLAG_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // done flag is derived from occupancy, so it cannot drop while entries wait
  wire       next_done  = (next_count != {CW{1'b0}});  // see RULE_09
  wire [1:0] next_flags = {overflow_flag | lost, next_done};

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      transfer_done_flag_o <= 1'b0;
      fifo_full_o          <= 1'b0;
      irq_o                <= 1'b0;
    end
    else
    begin
      transfer_done_flag_o <= next_done;
      fifo_full_o          <= (next_count == DEPTH[CW-1:0]);
      irq_o                <= |(next_flags & int_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after request, unmapped reads zero

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= bus_req;
      dat_o <= 32'h00000000;  // see RULE_05
      if (bus_req && !we_i)
      begin
        case (adr_i)
          `USTS_ADDR_STATUS:
          begin
            // contents undefined when empty; zero is shown then, see RULE_07
            if (!fifo_empty)
            begin
              dat_o[`USTS_EP_HI:`USTS_EP_LO] <= head_entry[5:2];  // see RULE_01
              dat_o[`USTS_DIR_BIT]  <= head_entry[1];  // see RULE_03
              dat_o[`USTS_BANK_BIT] <= head_entry[0];  // see RULE_04
            end
          end
          `USTS_ADDR_FLAGS:
          begin
            dat_o[`USTS_FLAG_DONE] <= ~fifo_empty;
            dat_o[`USTS_FLAG_OVF]  <= overflow_flag;
          end
          `USTS_ADDR_MASK:
          begin
            dat_o[`USTS_FLAG_W-1:0] <= int_mask;
          end
          default:
          begin
            dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // usb_transfer_status_fifo

//--- test/usb_transfer_status_fifo_checker.sv
`timescale 1ns/1ns
module usb_transfer_status_fifo_checker (
  input wire        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, xfer_done_i,
  input wire        transfer_done_flag_o, fifo_full_o, irq_o,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i, dat_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_ack_req; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("request not acked");
  property p_zero; ack_o |-> dat_o[31:8] == 24'h0 && ($past(adr_i) != 8'h00 || dat_o[1:0] == 2'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside ack");
  property p_push; xfer_done_i |=> transfer_done_flag_o; endproperty
  a_push: assert property (p_push) else $error("push left flag low");
  property p_pop;
    $fell(transfer_done_flag_o) |-> ack_o && $past(we_i && adr_i == 8'h04 && dat_i[0] && sel_i[0]);
  endproperty
  a_pop: assert property (p_pop) else $error("flag fell without pop");
  property p_full; fifo_full_o |-> transfer_done_flag_o; endproperty
  a_full: assert property (p_full) else $error("full but empty");
  property p_full_rise; $rose(fifo_full_o) |-> $past(xfer_done_i); endproperty
  a_full_rise: assert property (p_full_rise) else $error("full without push");
  cover property (fifo_full_o);
  cover property ($fell(transfer_done_flag_o));
  cover property (irq_o);
endmodule // usb_transfer_status_fifo_checker
bind usb_transfer_status_fifo usb_transfer_status_fifo_checker usb_transfer_status_fifo_checker_i (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .xfer_done_i, .transfer_done_flag_o,
  .fifo_full_o, .irq_o, .adr_i, .sel_i, .dat_i, .dat_o);

//--- test/usb_transfer_status_fifo_tb.sv
`timescale 1ns/1ns
module usb_transfer_status_fifo_tb;
  reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  reg         xfer_done_i = 0, xfer_tx_i = 0, xfer_odd_i = 0;
  reg  [7:0]  adr_i = 0;
  reg  [3:0]  sel_i = 0, xfer_endpoint_i = 0;
  reg  [31:0] dat_i = 0, rd;
  wire [31:0] dat_o;
  wire        ack_o, irq_o, transfer_done_flag_o, fifo_full_o;
  reg  [5:0]  ent [0:4] = '{6'h00, 6'h3f, 6'h16, 6'h29, 6'h0f};
  integer     n_errors = 0, n_checks = 0, i;
  usb_transfer_status_fifo usb_transfer_status_fifo_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .xfer_done_i, .xfer_endpoint_i, .xfer_tx_i,
    .xfer_odd_i, .irq_o, .transfer_done_flag_o, .fifo_full_o);
  initial forever #50 clk_i = ~clk_i;
  //////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    integer k;
    begin
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
      k = 0;
      do @(posedge clk_i); while (ack_o !== 1'b1 && ++k < 9);
      chk(ack_o, 1);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
    end
  endtask
  // entry packs endpoint, tx and odd bank
  task push(input [5:0] e);
    begin
      @(posedge clk_i);
      {xfer_done_i, xfer_endpoint_i, xfer_tx_i, xfer_odd_i} <= {1'b1, e};
      @(posedge clk_i);
      xfer_done_i <= 0;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_reset;
    for (i = 0; i < 3; i++)
    begin
      wb(0, 8'(4 * i), 0, 4'hf);
      chk(rd, 0);
    end
  endtask
  // fifth push finds the fifo full and must be dropped
  task t_fifo;
    begin
      for (i = 0; i < 5; i++) push(ent[i]);
      chk(fifo_full_o, 1);
      for (i = 0; i < 4; i++)
      begin
        wb(0, 8'h00, 0, 4'hf);
        chk(rd, {24'h0, ent[i], 2'b00});
        wb(1, 8'h04, 1, 4'hf);
        chk(transfer_done_flag_o, i < 3);
      end
      wb(0, 8'h04, 0, 4'hf);
      chk(rd, 2);
    end
  endtask
  task t_irq;
    begin
      wb(1, 8'h08, 2, 4'hf);
      wb(0, 8'h08, 0, 4'hf);
      chk(irq_o, 1);
      wb(1, 8'h04, 2, 4'hf);
      wb(0, 8'h04, 0, 4'hf);
      chk(irq_o, 0);
      wb(1, 8'h08, 1, 4'hf);
      push(6'h21);
      wb(1, 8'h00, 32'hffffffff, 4'hf);
      wb(1, 8'h04, 1, 4'he);
      wb(1, 8'h40, 1, 4'hf);
      wb(0, 8'h40, 0, 4'hf);
      chk(rd, 0);
      wb(0, 8'h00, 0, 4'hf);
      chk(rd, 32'h84);
      chk(irq_o, 1);
      wb(1, 8'h04, 1, 4'hf);
      wb(0, 8'h04, 0, 4'hf);
      chk(irq_o, 0);
    end
  endtask
  // reset in mid-run with an entry held must empty the fifo
  task t_rst_mid;
    begin
      push(6'h15);
      @(posedge clk_i);
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      chk({irq_o, transfer_done_flag_o, fifo_full_o, ack_o}, 0);
      wb(0, 8'h00, 0, 4'hf);
      chk(rd, 0);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_fifo;
    t_irq;
    t_rst_mid;
    final_report;
  end
  initial
  begin
    #400000;
    n_errors = n_errors + 1;
    final_report;
  end
endmodule // usb_transfer_status_fifo_tb
